/* tsf_pkg.sv */
`default_nettype none
package tsf_pkg;
   localparam int          AW          = 8;
   localparam int          DW          = 16;
   localparam logic [7:0]  OFF_CTRL    = 8'h00;
   localparam logic [7:0]  OFF_IEN     = 8'h0C;
   localparam logic [7:0]  OFF_STS     = 8'h10;
   localparam logic [7:0]  OFF_CEG     = 8'h14;
   localparam logic [7:0]  OFF_CCR0    = 8'h34;
   localparam logic [7:0]  CCR_STRIDE  = 8'h04;
   localparam int          NCH         = 4;
   localparam int          BIT_UPD     = 0;
   localparam int          BIT_CH0     = 1;
   localparam int          BIT_TRG     = 6;
   localparam int          BIT_OVC0    = 9;
   localparam int          CTRL_UDIS   = 1;
   localparam int          CTRL_URS    = 2;
   localparam int          CTRL_DIR0   = 8;
   localparam logic [15:0] STS_MASK    = 16'h1E5F;
   localparam logic [15:0] STS_RESET   = 16'h0000;
endpackage : tsf_pkg
`default_nettype wire

/* tsf_status.sv */
// How it works
// RULE1: Reset clears every status flag to zero.
// RULE2: Update event sets sticky update flag bit0.
// RULE3: Repetition overflow sets update unless update disabled.
// RULE4: Software update generate sets flag when allowed.
// RULE5: Trigger counter reinit sets update when allowed.
// RULE6: Output channel sets flag on compare match.
// RULE7: Input capture sets flag; read clears.
// RULE8: Channels two to four behave like one.
// RULE9: Trigger event sets sticky trigger flag bit6.
// RULE10: Capture while flag set marks overcapture.
// RULE11: Overcapture flags for channels two to four.
// RULE12: Interrupt only for enabled set flags.
// RULE13: Writing one ignored; reserved bits read zero.
// RULE14: Hardware set beats same-cycle software clear.
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
module tsf_status #(
   parameter int CW = 16
) (
   input  wire  logic                      CORE_CLK,
   input  wire  logic                      RST,
   input  wire  logic [tsf_pkg::AW-1:0]    ADDR,
   input  wire  logic [tsf_pkg::DW-1:0]    WDATA,
   input  wire  logic                      WR,
   input  wire  logic                      RD,
   output var   logic [tsf_pkg::DW-1:0]    RDATA,
   output var   logic                      IRQ,
   input  wire  logic [CW-1:0]             COUNTER_VALUE,
   input  wire  logic                      REPEAT_OVF,
   input  wire  logic                      TRIG_RELOAD,
   input  wire  logic                      TRIG_EVENT,
   input  wire  logic [tsf_pkg::NCH-1:0]   CAPTURE
);

   if (CW < 1 || CW > tsf_pkg::DW)
   begin : g_bad_cw
      $error("Counter width must lie between 1 and the data width.");
   end

   typedef struct packed {
      logic                                udis;
      logic                                urs;
      logic [tsf_pkg::NCH-1:0]             dir;
      logic [15:0]                         ien;
      logic [15:0]                         sts;
      logic [tsf_pkg::NCH-1:0][CW-1:0]     ccr;
      logic [tsf_pkg::DW-1:0]              rdata;
      logic                                irq;
   } tsf_state_t;

   tsf_state_t  s_q;
   tsf_state_t  s_d;
   logic [15:0] set_v;
   logic [15:0] clr_v;

   // Returns true when the address selects the given channel's value register.
   function automatic logic is_ccr(input logic [tsf_pkg::AW-1:0] a, input int ch);
      logic [tsf_pkg::AW-1:0] off;
      off = tsf_pkg::OFF_CCR0 + tsf_pkg::CCR_STRIDE * (tsf_pkg::AW)'(ch);
      return a == off;
   endfunction : is_ccr

   always_comb
   begin
      logic [15:0] ceg;
      logic        upd_ok;
      logic        gen_ok;
      logic        cap;
      cap    = 1'b0;
      s_d    = s_q;
      set_v  = 16'h0000;
      clr_v  = 16'h0000;
      ceg    = (WR && ADDR == tsf_pkg::OFF_CEG) ? WDATA : 16'h0000;
      upd_ok = !s_q.udis;
      gen_ok = !s_q.urs && !s_q.udis;
      // Update event sources and their gating.
      set_v[tsf_pkg::BIT_UPD] = (REPEAT_OVF && upd_ok) // RULE2 RULE3
                              || ((ceg[tsf_pkg::BIT_UPD] || TRIG_RELOAD) && gen_ok); // RULE4 RULE5
      set_v[tsf_pkg::BIT_TRG] = TRIG_EVENT || ceg[tsf_pkg::BIT_TRG]; // RULE9
      for (int i = 0; i < tsf_pkg::NCH; i++)
      begin
         cap = CAPTURE[i] || ceg[tsf_pkg::BIT_CH0 + i];
         if (s_q.dir[i])
         begin
            if (cap)
            begin
               s_d.ccr[i]                  = COUNTER_VALUE; // RULE7 RULE8
               set_v[tsf_pkg::BIT_CH0 + i] = 1'b1; // RULE7 RULE8
               set_v[tsf_pkg::BIT_OVC0 + i] = s_q.sts[tsf_pkg::BIT_CH0 + i]; // RULE10 RULE11
            end
         end
         else
         begin
            set_v[tsf_pkg::BIT_CH0 + i] = (COUNTER_VALUE == s_q.ccr[i]) // RULE6 RULE8
                                        || ceg[tsf_pkg::BIT_CH0 + i];
            if (WR && is_ccr(ADDR, i))
            begin
               s_d.ccr[i] = WDATA[CW-1:0];
            end
         end
         if (RD && is_ccr(ADDR, i))
         begin
            clr_v[tsf_pkg::BIT_CH0 + i] = 1'b1; // RULE7 RULE8
         end
      end
      if (WR && ADDR == tsf_pkg::OFF_STS)
      begin
         clr_v = clr_v | ~WDATA; // RULE13
      end
      if (WR && ADDR == tsf_pkg::OFF_CTRL)
      begin
         s_d.udis = WDATA[tsf_pkg::CTRL_UDIS];
         s_d.urs  = WDATA[tsf_pkg::CTRL_URS];
         s_d.dir  = WDATA[tsf_pkg::CTRL_DIR0 +: tsf_pkg::NCH];
      end
      if (WR && ADDR == tsf_pkg::OFF_IEN)
      begin
         s_d.ien = WDATA & tsf_pkg::STS_MASK;
      end
      // The set term is applied last so a same-cycle clear cannot lose it.
      s_d.sts = ((s_q.sts & ~clr_v) | set_v) & tsf_pkg::STS_MASK; // RULE2 RULE13 RULE14
      s_d.irq = |(s_d.sts & s_d.ien); // RULE12
      s_d.rdata = 16'h0000;
      if (RD)
      begin
         unique case (ADDR)
            tsf_pkg::OFF_CTRL:
            begin
               s_d.rdata[tsf_pkg::CTRL_UDIS]                 = s_q.udis;
               s_d.rdata[tsf_pkg::CTRL_URS]                  = s_q.urs;
               s_d.rdata[tsf_pkg::CTRL_DIR0 +: tsf_pkg::NCH] = s_q.dir;
            end
            tsf_pkg::OFF_IEN: s_d.rdata = s_q.ien;
            tsf_pkg::OFF_STS: s_d.rdata = s_q.sts; // RULE13
            default:
            begin
               for (int i = 0; i < tsf_pkg::NCH; i++)
               begin
                  if (is_ccr(ADDR, i))
                  begin
                     s_d.rdata[CW-1:0] = s_q.ccr[i];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         s_q     <= '0;
         s_q.sts <= tsf_pkg::STS_RESET; // RULE1
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign RDATA = s_q.rdata;
   assign IRQ   = s_q.irq;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   logic wr_sts;
   logic rd_ccr0;
   assign wr_sts  = WR && ADDR == tsf_pkg::OFF_STS;
   assign rd_ccr0 = RD && ADDR == tsf_pkg::OFF_CCR0;

   property p_reset;
      disable iff (1'b0) RST |=> s_q.sts == 16'h0000 && !IRQ;
   endproperty
   a_reset: assert property (p_reset) else $error("Status not cleared by reset."); // RULE1

   property p_upd_hold;
      s_q.sts[0] && !(wr_sts && !WDATA[0]) |=> s_q.sts[0];
   endproperty
   a_upd_hold: assert property (p_upd_hold) else $error("Update flag dropped."); // RULE2

   property p_upd_ovf;
      REPEAT_OVF |=> s_q.sts[0] == ($past(s_q.sts[0]) && !$past(wr_sts && !WDATA[0])
         || !$past(s_q.udis));
   endproperty
   a_upd_ovf: assert property (p_upd_ovf) else $error("Overflow update gating wrong."); // RULE3

   property p_upd_gen;
      WR && ADDR == tsf_pkg::OFF_CEG && WDATA[0] && !s_q.udis && !s_q.urs |=> s_q.sts[0];
   endproperty
   a_upd_gen: assert property (p_upd_gen) else $error("Generated update missed."); // RULE4

   property p_upd_trig;
      TRIG_RELOAD && !s_q.udis && !s_q.urs ##1 !(wr_sts && !WDATA[0])
         |-> s_q.sts[0] ##1 s_q.sts[0];
   endproperty
   a_upd_trig: assert property (p_upd_trig) else $error("Trigger reload update missed."); // RULE5

   property p_cmp;
      !s_q.dir[0] && COUNTER_VALUE == s_q.ccr[0] |=> s_q.sts[1];
   endproperty
   a_cmp: assert property (p_cmp) else $error("Compare match flag missed."); // RULE6

   property p_cap;
      s_q.dir[0] && CAPTURE[0] |=> s_q.sts[1] && s_q.ccr[0] == $past(COUNTER_VALUE);
   endproperty
   a_cap: assert property (p_cap) else $error("Capture not recorded."); // RULE7

   property p_rdclr;
      rd_ccr0 && s_q.dir[0] && !CAPTURE[0] && !(WR && ADDR == tsf_pkg::OFF_CEG) |=> !s_q.sts[1];
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("Value read did not clear flag."); // RULE7

   property p_cap4;
      s_q.dir[3] && CAPTURE[3] |=> s_q.sts[4] ##1 (s_q.sts[4] || $past(RD || WR));
   endproperty
   a_cap4: assert property (p_cap4) else $error("Channel four flag wrong."); // RULE8

   property p_trg;
      TRIG_EVENT |=> s_q.sts[6];
   endproperty
   a_trg: assert property (p_trg) else $error("Trigger flag missed."); // RULE9

   property p_ovc;
      s_q.dir[0] && CAPTURE[0] && s_q.sts[1] |=> s_q.sts[9];
   endproperty
   a_ovc: assert property (p_ovc) else $error("Overcapture missed."); // RULE10

   property p_ovc_out;
      !s_q.dir[2] && !s_q.sts[11] |=> !s_q.sts[11];
   endproperty
   a_ovc_out: assert property (p_ovc_out) else $error("Overcapture in output mode."); // RULE11

   property p_irq;
      ##1 IRQ == |(s_q.sts & s_q.ien);
   endproperty
   a_irq: assert property (p_irq) else $error("Interrupt does not follow flags."); // RULE12

   property p_rsv;
      (s_q.sts & ~tsf_pkg::STS_MASK) == 16'h0000;
   endproperty
   a_rsv: assert property (p_rsv) else $error("Reserved status bit set."); // RULE13

   property p_w1;
      wr_sts && WDATA == 16'hFFFF && s_q.sts[6] |=> s_q.sts[6];
   endproperty
   a_w1: assert property (p_w1) else $error("Write of one changed a flag."); // RULE13

   property p_prio;
      wr_sts && WDATA == 16'h0000 && TRIG_EVENT |=> s_q.sts[6];
   endproperty
   a_prio: assert property (p_prio) else $error("Set lost to same-cycle clear."); // RULE14

   property p_trg_hold;
      s_q.sts[6] && !(wr_sts && !WDATA[6]) |=> s_q.sts[6];
   endproperty
   a_trg_hold: assert property (p_trg_hold) else $error("Trigger flag dropped."); // RULE9

   property p_ovc_hold;
      s_q.sts[9] && !(wr_sts && !WDATA[9]) |=> s_q.sts[9];
   endproperty
   a_ovc_hold: assert property (p_ovc_hold) else $error("Overcapture flag dropped."); // RULE10

   property p_ovc_quiet;
      !CAPTURE[0] && !(WR && ADDR == tsf_pkg::OFF_CEG) && !s_q.sts[9] |=> !s_q.sts[9];
   endproperty
   a_ovc_quiet: assert property (p_ovc_quiet) else $error("Stray overcapture."); // RULE10

   property p_ovc_first;
      s_q.dir[1] && CAPTURE[1] && !s_q.sts[2] && !s_q.sts[10] |=> !s_q.sts[10];
   endproperty
   a_ovc_first: assert property (p_ovc_first) else $error("Early overcapture."); // RULE11

   property p_ovc2;
      s_q.dir[1] && CAPTURE[1] && s_q.sts[2] |=> s_q.sts[10];
   endproperty
   a_ovc2: assert property (p_ovc2) else $error("Channel two overcapture missed."); // RULE11

   property p_in_no_cmp;
      s_q.dir[0] && !CAPTURE[0] && !(WR && ADDR == tsf_pkg::OFF_CEG) && !s_q.sts[1]
         |=> !s_q.sts[1];
   endproperty
   a_in_no_cmp: assert property (p_in_no_cmp) else $error("Input flag without capture."); // RULE7

   property p_rd_sts;
      RD && ADDR == tsf_pkg::OFF_STS |=> RDATA == $past(s_q.sts);
   endproperty
   a_rd_sts: assert property (p_rd_sts) else $error("Status read wrong."); // RULE13

   property p_upd_dis;
      s_q.udis && !s_q.sts[0] |=> !s_q.sts[0];
   endproperty
   a_upd_dis: assert property (p_upd_dis) else $error("Update while disabled."); // RULE3

   property p_upd_urs;
      s_q.urs && !REPEAT_OVF && !s_q.sts[0] |=> !s_q.sts[0];
   endproperty
   a_upd_urs: assert property (p_upd_urs) else $error("Update despite select."); // RULE4 RULE5

   property p_upd_prio;
      wr_sts && !WDATA[0] && REPEAT_OVF && !s_q.udis |=> s_q.sts[0];
   endproperty
   a_upd_prio: assert property (p_upd_prio) else $error("Update lost to clear."); // RULE14

   property p_irq_off;
      s_q.ien == 16'h0000 && !(WR && ADDR == tsf_pkg::OFF_IEN) |=> !IRQ;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("Interrupt while masked."); // RULE12

   c_ovc: cover property (s_q.dir[1] && CAPTURE[1] && s_q.sts[2] ##1 s_q.sts[10]);
   c_irq: cover property (!IRQ ##1 IRQ ##[1:20] !IRQ);
   c_prio: cover property (wr_sts && WDATA == 16'h0000 && REPEAT_OVF && !s_q.udis);
   c_rdclr: cover property (rd_ccr0 && s_q.sts[1] ##1 !s_q.sts[1]);
   c_gen: cover property (WR && ADDR == tsf_pkg::OFF_CEG && WDATA[6] ##1 s_q.sts[6]);

endmodule : tsf_status
`default_nettype wire

/* tsf_status_tb.sv */
`default_nettype none
module tsf_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk   = 1'b0;
   logic        rst        = 1'b1;
   logic [7:0]  addr       = 8'h00;
   logic [15:0] wdata      = 16'h0000;
   logic        wr         = 1'b0;
   logic        rd         = 1'b0;
   logic [15:0] cnt        = 16'hFFFF;
   logic        rep        = 1'b0;
   logic        trl        = 1'b0;
   logic        tev        = 1'b0;
   logic [3:0]  cap        = 4'h0;
   logic [15:0] rdata;
   logic        irq;
   logic [15:0] v;
   int          num_errors = 0;
   int          n_tests    = 0;
   always #12.5 core_clk = ~core_clk;
   tsf_status #(.CW(16)) dut (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .COUNTER_VALUE(cnt), .REPEAT_OVF(rep),
      .TRIG_RELOAD(trl), .TRIG_EVENT(tev), .CAPTURE(cap));
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk);
      wr    <= 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task sts_is(input string nm, input logic [15:0] exp);
      rd_reg(tsf_pkg::OFF_STS, v);
      chk(nm, v, exp);
   endtask : sts_is
   task ev(input logic [6:0] e);
      @(posedge core_clk);
      {cap, tev, trl, rep} <= e;
      @(posedge core_clk);
      {cap, tev, trl, rep} <= 7'h00;
   endtask : ev
   task t_update;
      ev(7'h01);
      sts_is("update repeat", 16'h0001);
      wr_reg(tsf_pkg::OFF_STS, 16'hFFFF);
      sts_is("write one", 16'h0001);
      wr_reg(tsf_pkg::OFF_STS, 16'hFFFE);
      sts_is("update clear", 16'h0000);
      wr_reg(tsf_pkg::OFF_CEG, 16'h0001);
      sts_is("update generate", 16'h0001);
      wr_reg(tsf_pkg::OFF_STS, 16'h0000);
      ev(7'h02);
      sts_is("update trigger", 16'h0001);
      wr_reg(tsf_pkg::OFF_STS, 16'h0000);
      wr_reg(tsf_pkg::OFF_CTRL, 16'h0004);
      ev(7'h02);
      wr_reg(tsf_pkg::OFF_CEG, 16'h0001);
      sts_is("source select", 16'h0000);
      ev(7'h01);
      sts_is("repeat with select", 16'h0001);
      wr_reg(tsf_pkg::OFF_STS, 16'h0000);
      wr_reg(tsf_pkg::OFF_CTRL, 16'h0002);
      ev(7'h01);
      sts_is("update disabled", 16'h0000);
      wr_reg(tsf_pkg::OFF_CTRL, 16'h0000);
      ev(7'h04);
      sts_is("trigger", 16'h0040);
      wr_reg(tsf_pkg::OFF_STS, 16'h0000);
      $display("update and trigger test done");
   endtask : t_update
   task t_compare;
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(8'(tsf_pkg::OFF_CCR0 + tsf_pkg::CCR_STRIDE * i), 16'h0100 + 16'(i));
         @(posedge core_clk);
         cnt <= 16'h0100 + 16'(i);
         @(posedge core_clk);
         cnt <= 16'hFFFF;
         sts_is("compare", 16'h0002 << i);
         wr_reg(tsf_pkg::OFF_STS, 16'h0000);
      end
      $display("compare test done");
   endtask : t_compare
   task t_capture;
      wr_reg(tsf_pkg::OFF_CTRL, 16'h0F00);
      for (int i = 0; i < 4; i++)
      begin
         cnt <= 16'h1230 + 16'(i);
         ev(7'h08 << i);
         ev(7'h08 << i);
         sts_is("overcapture", 16'h0202 << i);
         rd_reg(8'(tsf_pkg::OFF_CCR0 + tsf_pkg::CCR_STRIDE * i), v);
         chk("captured value", v, 16'h1230 + 16'(i));
         sts_is("read clear", 16'h0200 << i);
         wr_reg(tsf_pkg::OFF_STS, 16'h0000);
      end
      ev(7'h08);
      @(posedge core_clk);
      addr  <= tsf_pkg::OFF_STS;
      wdata <= 16'h0000;
      wr    <= 1'b1;
      cap   <= 4'h1;
      @(posedge core_clk);
      wr    <= 1'b0;
      cap   <= 4'h0;
      sts_is("set beats clear", 16'h0202);
      wr_reg(tsf_pkg::OFF_STS, 16'h0000);
      $display("capture test done");
   endtask : t_capture
   task t_regs;
      wr_reg(tsf_pkg::OFF_CTRL, 16'h0F06);
      rd_reg(tsf_pkg::OFF_CTRL, v);
      chk("control readback", v, 16'h0F06);
      wr_reg(tsf_pkg::OFF_CTRL, 16'h0F00);
      wr_reg(tsf_pkg::OFF_IEN, 16'hFFFF);
      rd_reg(tsf_pkg::OFF_IEN, v);
      chk("enable readback", v, 16'h1E5F);
      wr_reg(tsf_pkg::OFF_CEG, 16'h0044);
      sts_is("event generate", 16'h0044);
      chk("irq generated", {15'h0000, irq}, 16'h0001);
      rd_reg(tsf_pkg::OFF_CCR0 + tsf_pkg::CCR_STRIDE, v);
      chk("generated capture", v, 16'h1233);
      sts_is("generate read clear", 16'h0040);
      wr_reg(tsf_pkg::OFF_STS, 16'h0000);
      wr_reg(tsf_pkg::OFF_IEN, 16'h0000);
      $display("register test done");
   endtask : t_regs
   task t_irq;
      wr_reg(tsf_pkg::OFF_IEN, 16'h0004);
      ev(7'h08);
      #1 chk("irq masked", {15'h0000, irq}, 16'h0000);
      wr_reg(tsf_pkg::OFF_IEN, 16'h0002);
      #1 chk("irq enabled", {15'h0000, irq}, 16'h0001);
      wr_reg(tsf_pkg::OFF_STS, 16'h0000);
      #1 chk("irq cleared", {15'h0000, irq}, 16'h0000);
      rd_reg(8'h20, v);
      chk("unmapped read", v, 16'h0000);
      ev(7'h04);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      sts_is("second reset", 16'h0000);
      $display("interrupt and reset test done");
   endtask : t_irq
   task test_done;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      sts_is("reset", 16'h0000);
      t_update();
      t_compare();
      t_capture();
      t_regs();
      t_irq();
      test_done();
   end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      test_done();
   end
endmodule : tsf_status_tb
`default_nettype wire
